/* File: hw/io_pin_consts.svh */
// Purpose: Offsets, field positions and reset values of the pin control block.
// Assumes: Byte-wide registers on a plain strobe port with an 8-bit address.
// Notes: Definitions only.
`ifndef IO_PIN_CONSTS_SVH
`define IO_PIN_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_PORT_B_PINS 8'h00
`define OFS_PORT_B_LAT 8'h01
`define OFS_PORT_B_DIR 8'h02
`define OFS_PORT_D_PINS 8'h03
`define OFS_PORT_D_LAT 8'h04
`define OFS_PORT_D_DIR 8'h05
`define OFS_PORT_E_PINS 8'h06
`define OFS_PORT_E_LAT 8'h07
`define OFS_PORT_E_DIR 8'h08
`define OFS_PORT_J_PINS 8'h09
`define OFS_PORT_J_LAT 8'h0A
`define OFS_PORT_J_DIR 8'h0B
`define OFS_SEVENTH_PINS 8'h0C
`define OFS_SEVENTH_LAT 8'h0D
`define OFS_SEVENTH_DIR 8'h0E
`define OFS_INTERRUPT_CTRL_TWO 8'h10
`define OFS_WATCHDOG_CTRL 8'h11
`define OFS_SHARED_A 8'h12
`define OFS_SHARED_B 8'h13
`define OFS_SHARED_C 8'h14
`define OFS_SECOND_TIMER 8'h15

// ****************************************
// Field positions
// ****************************************
`define BIT_PULLUP_B 7
`define BIT_PULLUP_D 7
`define BIT_PULLUP_E 6
`define BIT_PULLUP_J 5
`define BIT_SHARED_BANK 4
`define BIT_TTL_SELECT 0

// ****************************************
// Reset values and implemented masks
// ****************************************
`define RST_DIR 8'hFF
`define RST_ZERO 8'h00
`define MASK_CAPTURE_OD 8'h1F
`define MASK_SERIAL_OD 8'h03
`define MASK_SPI_OD 8'h03
`define MASK_PAD_CFG 8'h01
`define MASK_SEVENTH_LOW 8'h1F

`endif

/* File: hw/io_pin_pkg.sv */
// Purpose: Types of the pin control block.
// Assumes: Nothing beyond the constants header.
// Notes: Types only.
package io_pin_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    PORT_B = 2'h0,
    PORT_D = 2'h1,
    PORT_E = 2'h2,
    PORT_J = 2'h3
  } pullup_port_t;
endpackage

/* File: hw/io_pin_control.sv */
// Purpose: General purpose pin control with pull-ups, open-drain and pad select.
// Assumes: Pins and peripheral outputs synchronous to clk_in.
// Notes: Shared addresses reach the timer registers unless the bank bit is set.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "io_pin_consts.svh"

module io_pin_control #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Pins of the four pull-up ports
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_out,
  output logic [3:0] pullup_en_out,
  // Seventh port pins
  input wire logic [4:0] seventh_pin_in,
  output logic [4:0] seventh_pin_out,
  output logic [4:0] seventh_pin_oe_out,
  // Peripheral takeover on the four ports
  input wire logic [31:0] periph_en_in,
  input wire logic [31:0] periph_data_in,
  input wire logic [31:0] periph_oe_in,
  // Open-drain peripheral outputs: cc5,cc4,ecc3..1,serial2,1,sdo2,1
  input wire logic [8:0] od_periph_data_in,
  output logic [8:0] od_pin_out,
  output logic [8:0] od_pin_oe_out,
  // Parallel port input buffer select
  output logic parallel_ttl_select_out,
  // Timer side of the shared addresses
  output logic [1:0] timer_sel_out,
  output logic timer_wr_out,
  input wire logic [7:0] timer_rdata_in
);

  // ****************************************
  // Register state
  // ****************************************
  io_pin_pkg::byte_t lat_reg [4];
  io_pin_pkg::byte_t dir_reg [4];
  logic [4:0] seventh_lat_reg;
  logic [4:0] seventh_dir_reg;
  logic [2:0] seventh_pu_reg;
  logic pullup_en_b_reg;
  io_pin_pkg::byte_t watchdog_ctrl_reg;
  io_pin_pkg::byte_t capture_od_reg;
  io_pin_pkg::byte_t serial_od_reg;
  io_pin_pkg::byte_t spi_od_reg;
  io_pin_pkg::byte_t pad_cfg_reg;
  io_pin_pkg::byte_t rdata_reg;

  // ****************************************
  // Decode
  // ****************************************
  wire shared_bank_select = watchdog_ctrl_reg[`BIT_SHARED_BANK];
  wire [3:0] port_idx_raw = (addr_in < `OFS_SEVENTH_PINS) ? addr_in[3:0] / 4'h3 : 4'h0;
  wire [1:0] port_idx = port_idx_raw[1:0];
  wire [3:0] port_sub = (addr_in < `OFS_SEVENTH_PINS) ? addr_in[3:0] % 4'h3 : 4'h0;
  wire in_port = addr_in < `OFS_SEVENTH_PINS;
  wire hit_pins = in_port && port_sub == 4'h0;
  wire hit_lat = in_port && port_sub == 4'h1;
  wire hit_dir = in_port && port_sub == 4'h2;
  wire hit_shared = addr_in >= `OFS_SHARED_A && addr_in <= `OFS_SECOND_TIMER;
  wire cfg_access = hit_shared && shared_bank_select;
  wire [7:0] port_pins_rd = pin_in[port_idx*8 +: 8];
  wire [3:0] pullup_en = {seventh_pu_reg[0] & LARGE_PACKAGE, seventh_pu_reg[1],
    seventh_pu_reg[2], pullup_en_b_reg};

  // ****************************************
  // Address hits and write strobes
  // ****************************************
  wire hit_seventh_pins = addr_in == `OFS_SEVENTH_PINS;
  wire hit_seventh_lat = addr_in == `OFS_SEVENTH_LAT;
  wire hit_seventh_dir = addr_in == `OFS_SEVENTH_DIR;
  wire hit_intr_two = addr_in == `OFS_INTERRUPT_CTRL_TWO;
  wire hit_watchdog = addr_in == `OFS_WATCHDOG_CTRL;
  wire hit_capture_od = addr_in == `OFS_SHARED_A;
  wire hit_serial_od = addr_in == `OFS_SHARED_B;
  wire hit_spi_od = addr_in == `OFS_SHARED_C;
  wire hit_pad_cfg = addr_in == `OFS_SECOND_TIMER;
  wire wr_port_lat = wr_in && (hit_pins || hit_lat);
  wire wr_port_dir = wr_in && hit_dir;
  wire wr_seventh_lat = wr_in && (hit_seventh_pins || hit_seventh_lat);
  wire wr_seventh_pu = wr_in && hit_seventh_pins;
  wire wr_seventh_dir = wr_in && hit_seventh_dir;
  wire wr_pullup_b = wr_in && hit_intr_two;
  wire wr_watchdog = wr_in && hit_watchdog;
  wire wr_capture_od = wr_in && cfg_access && hit_capture_od;
  wire wr_serial_od = wr_in && cfg_access && hit_serial_od;
  wire wr_spi_od = wr_in && cfg_access && hit_spi_od;
  wire wr_pad_cfg = wr_in && cfg_access && hit_pad_cfg;

  // ****************************************
  // Register storage
  // ****************************************
  // Pins and latch addresses of each port share the latch strobe, gated by the port index.
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port_regs
      wire port_hit = port_idx == 2'(p);
      field_reg #(
        .WIDTH(8),
        .RESET_VALUE(`RST_ZERO)
      ) i_lat (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(wr_port_lat && port_hit),
        .wdata_in(wdata_in),
        .value_out(lat_reg[p])
      );
      field_reg #(
        .WIDTH(8),
        .RESET_VALUE(`RST_DIR)
      ) i_dir (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(wr_port_dir && port_hit),
        .wdata_in(wdata_in),
        .value_out(dir_reg[p])
      );
    end
  endgenerate

  field_reg #(
    .WIDTH(5),
    .RESET_VALUE(5'(`RST_ZERO))
  ) i_seventh_lat (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_seventh_lat),
    .wdata_in(wdata_in[4:0]),
    .value_out(seventh_lat_reg)
  );

  field_reg #(
    .WIDTH(5),
    .RESET_VALUE(5'(`RST_DIR))
  ) i_seventh_dir (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_seventh_dir),
    .wdata_in(wdata_in[4:0]),
    .value_out(seventh_dir_reg)
  );

  field_reg #(
    .WIDTH(3),
    .RESET_VALUE(3'(`RST_ZERO))
  ) i_seventh_pu (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_seventh_pu),
    .wdata_in(wdata_in[`BIT_PULLUP_D:`BIT_PULLUP_J]),
    .value_out(seventh_pu_reg)
  );

  field_reg #(
    .WIDTH(1),
    .RESET_VALUE(1'(`RST_ZERO))
  ) i_pullup_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_pullup_b),
    .wdata_in(wdata_in[`BIT_PULLUP_B]),
    .value_out(pullup_en_b_reg)
  );

  field_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_ZERO)
  ) i_watchdog (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_watchdog),
    .wdata_in(wdata_in),
    .value_out(watchdog_ctrl_reg)
  );

  // ****************************************
  // Configuration behind the shared bank
  // ****************************************
  field_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_ZERO)
  ) i_capture_od (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_capture_od),
    .wdata_in(wdata_in & `MASK_CAPTURE_OD),
    .value_out(capture_od_reg)
  );

  field_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_ZERO)
  ) i_serial_od (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_serial_od),
    .wdata_in(wdata_in & `MASK_SERIAL_OD),
    .value_out(serial_od_reg)
  );

  field_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_ZERO)
  ) i_spi_od (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_spi_od),
    .wdata_in(wdata_in & `MASK_SPI_OD),
    .value_out(spi_od_reg)
  );

  field_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_ZERO)
  ) i_pad_cfg (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_pad_cfg),
    .wdata_in(wdata_in & `MASK_PAD_CFG),
    .value_out(pad_cfg_reg)
  );

  // ****************************************
  // Register reads
  // ****************************************
  // Seventh port read mixes pin levels low with stored pull-up enables high.
  wire [7:0] seventh_rd = {seventh_pu_reg[2:1], seventh_pu_reg[0] & LARGE_PACKAGE,
    seventh_pin_in};
  wire [7:0] cfg_rd = (addr_in == `OFS_SHARED_A) ? capture_od_reg :
    (addr_in == `OFS_SHARED_B) ? serial_od_reg :
    (addr_in == `OFS_SHARED_C) ? spi_od_reg : pad_cfg_reg;
  wire [7:0] read_mux =
    hit_pins ? port_pins_rd :
    hit_lat ? lat_reg[port_idx] :
    hit_dir ? dir_reg[port_idx] :
    (addr_in == `OFS_SEVENTH_PINS) ? seventh_rd :
    (addr_in == `OFS_SEVENTH_LAT) ? {3'h0, seventh_lat_reg} :
    (addr_in == `OFS_SEVENTH_DIR) ? {3'h0, seventh_dir_reg} :
    (addr_in == `OFS_INTERRUPT_CTRL_TWO) ? {pullup_en_b_reg, 7'h00} :
    (addr_in == `OFS_WATCHDOG_CTRL) ? watchdog_ctrl_reg :
    cfg_access ? cfg_rd :
    hit_shared ? timer_rdata_in : 8'h00;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 8'h00;
    end else if (rd_in) begin
      rdata_reg <= read_mux;
    end
  end
  assign rdata_out = rdata_reg;

  // ****************************************
  // Timer side of shared addresses
  // ****************************************
  wire [7:0] shared_offset = addr_in - `OFS_SHARED_A;
  assign timer_sel_out = shared_offset[1:0];
  assign timer_wr_out = wr_in && hit_shared && !shared_bank_select;

  // ****************************************
  // Pin drivers
  // ****************************************
  // A taken-over pin follows its peripheral so software cannot fight it.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      wire [7:0] take_over = periph_en_in[g*8 +: 8];
      assign pin_out[g*8 +: 8] = (take_over & periph_data_in[g*8 +: 8]) |
        (~take_over & lat_reg[g]);
      assign pin_oe_out[g*8 +: 8] = (take_over & periph_oe_in[g*8 +: 8]) |
        (~take_over & ~dir_reg[g]);
    end
  endgenerate
  assign seventh_pin_out = seventh_lat_reg;
  assign seventh_pin_oe_out = ~seventh_dir_reg;
  assign pullup_en_out = pullup_en;

  // Pins with their open-drain bit set only pull low; a high is left to the external pull-up.
  wire [8:0] od_en = {capture_od_reg[4:0], serial_od_reg[1:0], spi_od_reg[1:0]};
  assign od_pin_out = od_periph_data_in & ~od_en;
  assign od_pin_oe_out = ~od_en | ~od_periph_data_in;

  assign parallel_ttl_select_out = pad_cfg_reg[`BIT_TTL_SELECT];

endmodule

// ****************************************
// Writable register field
// ****************************************
// A field stores every bit it is written; the shared-bank registers mask their writes so the rest never keep stray values.
module field_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // Stored value
  output logic [WIDTH-1:0] value_out
);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_out <= RESET_VALUE;
    end else if (wr_en_in) begin
      value_out <= wdata_in;
    end
  end

endmodule

/* File: testbench/io_pin_asserts.sv */
// Purpose: Port checks of the pin control block.
// Assumes: Port b and the shared bank are exercised.
// Notes: Timer reads are not modelled here, since the bank bit lives inside.
`timescale 1ns/1ps
module io_pin_asserts #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Ports of the pin control block
  input wire logic clk_in, rst_n_in, wr_in, rd_in, parallel_ttl_select_out, timer_wr_out,
  input wire logic [7:0] addr_in, wdata_in, rdata_out, timer_rdata_in,
  input wire logic [31:0] pin_in, pin_out, pin_oe_out,
  input wire logic [31:0] periph_en_in, periph_data_in, periph_oe_in,
  input wire logic [3:0] pullup_en_out,
  input wire logic [4:0] seventh_pin_in, seventh_pin_out, seventh_pin_oe_out,
  input wire logic [8:0] od_periph_data_in, od_pin_out, od_pin_oe_out,
  input wire logic [1:0] timer_sel_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_PIN_READ: assert property (rd_in && addr_in == 8'h00 |=> rdata_out == $past(pin_in[7:0]))
    else $error("pin read mismatch");
  AST_DIR_DRIVE: assert property (wr_in && addr_in == 8'h02 |=>
    (pin_oe_out[7:0] & ~periph_en_in[7:0]) == (~$past(wdata_in) & ~periph_en_in[7:0]))
    else $error("direction mismatch");
  AST_LATCH_DRIVE: assert property (wr_in && addr_in <= 8'h01 |=>
    ((pin_out[7:0] ^ $past(wdata_in)) & pin_oe_out[7:0] & ~periph_en_in[7:0]) == 8'h00)
    else $error("latch drive mismatch");
  AST_PERIPH: assert property ((pin_oe_out & periph_en_in) == (periph_oe_in & periph_en_in))
    else $error("peripheral takeover mismatch");
  AST_PULLUP_B: assert property (wr_in && addr_in == 8'h10 |=>
    pullup_en_out[0] == $past(wdata_in[7])) else $error("pull-up b mismatch");
  AST_PULLUP_DEJ: assert property (wr_in && addr_in == 8'h0C |=>
    {pullup_en_out[1], pullup_en_out[2], pullup_en_out[3]} ==
    ($past(wdata_in[7:5]) & {2'b11, LARGE_PACKAGE}))
    else $error("pull-up d e j mismatch");
  AST_OD_DRIVE: assert property ((od_pin_oe_out & od_pin_out) == (od_pin_oe_out & od_periph_data_in))
    else $error("open-drain drive mismatch");
  AST_OD_RELEASE: assert property ((~od_pin_oe_out & od_periph_data_in) == ~od_pin_oe_out)
    else $error("open-drain release mismatch");
  AST_TIMER_SEL: assert property (addr_in >= 8'h12 && addr_in <= 8'h15 |->
    timer_sel_out == 2'(addr_in - 8'h12)) else $error("timer select mismatch");
  AST_UNMAPPED: assert property (rd_in && addr_in == 8'hF0 |=> rdata_out == 8'h00)
    else $error("unmapped read mismatch");
endmodule
bind io_pin_control io_pin_asserts #(.LARGE_PACKAGE(LARGE_PACKAGE)) i_io_pin_asserts (.*);

/* File: testbench/pin_board_model.sv */
// Purpose: Pins and board logic of the four pull-up ports.
// Assumes: Board drives only where drive_en_in is set.
// Notes: A floating pin with no pull-up toggles each cycle so that no stale value is read.
`timescale 1ns/1ps
module pin_board_model (
  input wire logic clk_in,
  input wire logic [31:0] pin_out_in,
  input wire logic [31:0] pin_oe_in,
  input wire logic [31:0] drive_val_in,
  input wire logic [31:0] drive_en_in,
  input wire logic [3:0] pullup_en_in,
  output logic [31:0] pin_level_out
);
  logic [31:0] float_pat = 32'h0;
  wire [31:0] pull_mask = {{8{pullup_en_in[3]}}, {8{pullup_en_in[2]}},
    {8{pullup_en_in[1]}}, {8{pullup_en_in[0]}}};
  always @(posedge clk_in) float_pat <= ~float_pat;
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_en_in & drive_val_in)
    | (~pin_oe_in & ~drive_en_in & (pull_mask | float_pat));
endmodule

/* File: testbench/testbench.sv */
// Purpose: Register level tests of the pin control block.
// Assumes: Large package build.
// Notes: The board drives port b bits 7..4 to 3.
`timescale 1ns/1ps
module testbench;
  logic clk_in, rst_n_in, wr_in, rd_in, parallel_ttl_select_out, timer_wr_out;
  logic [7:0] addr_in, wdata_in, rdata_out, timer_rdata_in;
  logic [31:0] pin_in, pin_out, pin_oe_out, periph_en_in, periph_data_in, periph_oe_in;
  logic [3:0] pullup_en_out;
  logic [4:0] seventh_pin_in, seventh_pin_out, seventh_pin_oe_out;
  logic [8:0] od_periph_data_in, od_pin_out, od_pin_oe_out;
  logic [1:0] timer_sel_out;
  logic [7:0] masks [4] = '{8'h1F, 8'h03, 8'h03, 8'h01};
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int timer_writes = 0;
  io_pin_control i_io_pin_control (.*);
  pin_board_model i_pin_board_model (.clk_in(clk_in), .pin_out_in(pin_out),
    .pin_oe_in(pin_oe_out), .drive_val_in(32'h30), .drive_en_in(32'hF0),
    .pullup_en_in(pullup_en_out), .pin_level_out(pin_in));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk("read data", exp, rdata_out);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // A hang is cut short well beyond the fewer than one hundred cycles the tests need.
  always @(posedge clk_in) begin
    cycles++;
    if (timer_wr_out === 1'b1) timer_writes++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    {rst_n_in, wr_in, rd_in, addr_in, wdata_in, seventh_pin_in} = '0;
    {periph_en_in, periph_data_in, periph_oe_in, od_periph_data_in} = '0;
    timer_rdata_in = 8'h3C;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk("pin drive enables", 32'h0, pin_oe_out);
    rd(8'h02, 8'hFF);
    wr(8'h00, 8'hA5);
    wr(8'h02, 8'hF0);
    @(negedge clk_in);
    chk("port b drive", 8'h05, pin_out[7:0] & pin_oe_out[7:0]);
    rd(8'h01, 8'hA5);
    rd(8'h00, 8'h35);
    wr(8'h10, 8'h80);
    wr(8'h0C, 8'h80);
    @(negedge clk_in);
    chk("pull-up b and d", 4'h3, pullup_en_out);
    wr(8'h0C, 8'hE0);
    @(negedge clk_in);
    chk("pull-up enables", 4'hF, pullup_en_out);
    rd(8'h03, 8'hFF);
    @(posedge clk_in);
    seventh_pin_in <= 5'h0A;
    wr(8'h0E, 8'h03);
    wr(8'h0D, 8'h15);
    @(negedge clk_in);
    chk("seventh drive enables", 5'h1C, seventh_pin_oe_out);
    chk("seventh pins", 5'h15, seventh_pin_out);
    rd(8'h0C, 8'hEA);
    rd(8'h0D, 8'h15);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h3C);
    wr(8'h11, 8'h10);
    rd(8'h13, 8'h00);
    rd(8'h12, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'h12 + 8'(i), 8'hFF);
    for (int i = 0; i < 4; i++) rd(8'h12 + 8'(i), masks[i]);
    chk("buffer select", 1'b1, parallel_ttl_select_out);
    chk("open-drain low", 9'h1FF, od_pin_oe_out);
    @(posedge clk_in);
    od_periph_data_in <= 9'h1FF;
    @(negedge clk_in);
    chk("open-drain high", 9'h000, od_pin_oe_out);
    chk("open-drain out", 9'h000, od_pin_out);
    wr(8'h11, 8'h00);
    wr(8'h15, 8'h00);
    wr(8'h11, 8'h10);
    rd(8'h15, 8'h01);
    rd(8'hF0, 8'h00);
    @(posedge clk_in);
    periph_en_in <= 32'hFF;
    periph_oe_in <= 32'hFF;
    periph_data_in <= 32'h5A;
    @(negedge clk_in);
    chk("peripheral pins", 8'h5A, pin_out[7:0]);
    chk("timer writes", 32'h2, timer_writes);
    wrap_up();
  end
endmodule
